// ### hdl/i2c_irq_ctrl.v
// I2C interrupt mask, raw status and flag logic behind an AHB-Lite slave
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "i2c_irq_map.vh"
module i2c_irq_ctrl #(
  parameter LEVEL_W = `LEVEL_WIDTH,  // FIFO level width
  parameter THR_W   = `THR_WIDTH     // Threshold field width
) (
  input  wire                    clk_sys,        // System clock, 10 MHz
  input  wire                    rstn,           // Asynchronous reset, active low
  input  wire                    hsel,           // AHB slave select
  input  wire [31:0]             haddr,          // AHB address
  input  wire [1:0]              htrans,         // AHB transfer type
  input  wire                    hwrite,         // AHB write
  input  wire [2:0]              hsize,          // AHB size
  input  wire [31:0]             hwdata,         // AHB write data
  input  wire                    hready,         // AHB bus ready
  output wire                    hreadyout,      // AHB slave ready
  output wire                    hresp,          // AHB response
  output reg  [31:0]             hrdata,         // AHB read data
  input  wire                    ctrl_enable,    // Controller enabled
  input  wire                    fsm_active,     // Master or slave machine busy
  input  wire                    gen_call_ack,   // General call address acked
  input  wire                    start_seen,     // START or repeated START seen
  input  wire                    stop_seen,      // STOP seen
  input  wire                    slv_tx_nack,    // Slave transmitter byte not acked
  input  wire                    tx_abort_evt,   // Transmit abort event
  input  wire [`CAUSE_WIDTH-1:0] tx_abort_cause, // Reason for the abort
  input  wire                    rd_req_evt,     // Remote master requests read
  input  wire                    tx_over_evt,    // Push into full transmit FIFO
  input  wire                    rx_over_evt,    // Byte received into full FIFO
  input  wire                    rx_under_evt,   // Pop from empty receive FIFO
  input  wire [LEVEL_W-1:0]      tx_level,       // Transmit FIFO level
  input  wire [LEVEL_W-1:0]      rx_level,       // Receive FIFO level
  output reg                     tx_fifo_flush,  // Hold transmit FIFO in reset
  output reg  [THR_W-1:0]        tx_threshold,   // Transmit threshold to datapath
  output reg  [THR_W-1:0]        rx_threshold,   // Receive threshold to datapath
  output reg                     irq             // Level interrupt request
);

  // Only flag and register state lives here; FIFOs, transfer machines
  // and threshold clamping sit outside this block
  // hsize is not decoded: narrow writes land as words

  // Reset synchroniser
  reg                      rst_meta_q;      // First reset stage
  reg                      rst_sync_q;      // Second reset stage
  wire                     rst_n;           // Released reset copy

  // Bus address phase capture
  reg                      wr_pend_q;       // Write data phase pending
  reg  [31:0]              wr_addr_q;       // Address of pending write
  wire                     bus_take;        // Valid transfer accepted
  wire                     rd_take;         // Read accepted this cycle

  // Software state
  reg  [`FLAG_COUNT-1:0]   mask_q;          // Interrupt mask
  reg  [THR_W-1:0]         tx_thr_q;        // Transmit threshold
  reg  [THR_W-1:0]         rx_thr_q;        // Receive threshold
  reg  [`CAUSE_WIDTH-1:0]  abort_cause_q;   // Captured abort reason
  reg  [`FLAG_COUNT-1:0]   raw_prev_q;      // Raw flags last cycle
  reg  [`FLAG_COUNT-1:0]   event_latch_q;   // Sticky rising-edge latch

  // Flag plumbing
  wire [`FLAG_COUNT-1:0]   raw;             // Raw status
  wire [`FLAG_COUNT-1:0]   masked;          // Masked status
  reg  [`FLAG_COUNT-1:0]   set_vec;         // Per-flag set
  reg  [`FLAG_COUNT-1:0]   clr_vec;         // Per-flag clear
  wire                     idle_off;        // Disabled and machines idle
  wire                     rd_combined;     // Combined clear read
  wire                     rd_gen_call;     // General call clear read
  wire                     rd_activity;     // Activity clear read
  wire                     rd_abort;        // Abort clear read
  wire                     rd_rd_req;       // Read request clear read
  wire [`FLAG_COUNT-1:0]   latch_w1c;       // Write-one-to-clear bits
  reg  [31:0]              rd_mux;          // Read data selection
  wire                     tx_empty_q;      // Transmit empty flag
  wire                     rx_full_q;       // Receive full flag

  // Two-stage release of the asynchronous reset
  // Assert at once, release on the clock so no flop sees
  // a reset edge too close to its clock edge
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // Pin low: both stages clear at once
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      // Pin high: a one ripples through two stages
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Only the second stage feeds the logic
  assign rst_n = rst_sync_q;

  // Zero wait state slave, always OKAY
  // One-cycle answer, so no stall
  assign hreadyout = 1'b1;
  assign hresp     = `HRESP_OKAY;

  // Transfer accepted when selected, active and bus ready
  // Idle and busy transfers are ignored
  assign bus_take = hsel & hready & htrans[1];
  assign rd_take  = bus_take & ~hwrite;

  // Read-to-clear strobes act at the accepted address phase
  // Read returns the flag, then it clears
  assign rd_combined = rd_take & (haddr == `ADDR_COMBINED_CLR);
  assign rd_gen_call = rd_take & (haddr == `ADDR_GEN_CALL_CLR);
  assign rd_activity = rd_take & (haddr == `ADDR_ACTIVITY_CLR);
  assign rd_abort    = rd_take & (haddr == `ADDR_ABORT_CLR);
  assign rd_rd_req   = rd_take & (haddr == `ADDR_RD_REQ_CLR);

  // Machines idle with controller off ends the error flags
  // Disabled but busy keeps the error flags
  assign idle_off = ~ctrl_enable & ~fsm_active;

  // Write address phase capture for the following data phase
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Nothing pending out of reset
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h00000000;
    end else if (hready) begin
      // Capture only when the bus moves on
      wr_pend_q <= bus_take & hwrite;
      wr_addr_q <= haddr;
    end
  end

  // Write-one-to-clear of the event latch in the data phase
  assign latch_w1c = (wr_pend_q && wr_addr_q == `ADDR_EVENT_LATCH) ?
                     hwdata[`FLAG_COUNT-1:0] : {`FLAG_COUNT{1'b0}};

  // Writable registers; only word writes are defined, others still land
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Start, stop and activity masked off
      mask_q   <= `MASK_RESET;
      tx_thr_q <= `THR_RESET;
      rx_thr_q <= `THR_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `ADDR_INTR_MASK) begin
        // Bits above 11 are dropped here
        mask_q <= hwdata[`FLAG_COUNT-1:0];
      end else if (wr_addr_q == `ADDR_TX_THRESHOLD) begin
        // Transmit threshold, low bits only
        tx_thr_q <= hwdata[THR_W-1:0];
      end else if (wr_addr_q == `ADDR_RX_THRESHOLD) begin
        // Receive threshold, low bits only
        rx_thr_q <= hwdata[THR_W-1:0];
      end
      // Read-only and unmapped writes fall through
    end
  end

  // Per-flag set sources
  always @* begin
    set_vec                = {`FLAG_COUNT{1'b0}};
    // Bus events from the transfer machines
    set_vec[`BIT_GEN_CALL] = gen_call_ack;
    set_vec[`BIT_START]    = start_seen;
    set_vec[`BIT_STOP]     = stop_seen;
    set_vec[`BIT_ACTIVITY] = fsm_active;
    set_vec[`BIT_TX_DONE]  = slv_tx_nack;
    set_vec[`BIT_TX_ABORT] = tx_abort_evt;
    // Read request and FIFO misuse pulses
    set_vec[`BIT_RD_REQ]   = rd_req_evt;
    set_vec[`BIT_TX_OVER]  = tx_over_evt;
    set_vec[`BIT_RX_OVER]  = rx_over_evt;
    set_vec[`BIT_RX_UNDER] = rx_under_evt;
  end

  // Per-flag clear sources; level flags are handled apart
  always @*  begin
    clr_vec                = {`FLAG_COUNT{1'b0}};
    // Disable clears general call and activity
    clr_vec[`BIT_GEN_CALL] = rd_gen_call | rd_combined | ~ctrl_enable;
    // Start, stop and done need the combined read
    clr_vec[`BIT_START]    = rd_combined;
    clr_vec[`BIT_STOP]     = rd_combined;
    clr_vec[`BIT_ACTIVITY] = rd_activity | rd_combined | ~ctrl_enable;
    clr_vec[`BIT_TX_DONE]  = rd_combined;
    clr_vec[`BIT_TX_ABORT] = rd_abort | rd_combined;
    clr_vec[`BIT_RD_REQ]   = rd_rd_req | rd_combined;
    // Error flags hold while machines still run
    clr_vec[`BIT_TX_OVER]  = rd_combined | idle_off;
    clr_vec[`BIT_RX_OVER]  = rd_combined | idle_off;
    clr_vec[`BIT_RX_UNDER] = rd_combined | idle_off;
  end

  // One sticky cell per event flag
  genvar gi;
  generate
    for (gi = 0; gi < `FLAG_COUNT; gi = gi + 1) begin : g_flag
      if (gi == `BIT_TX_EMPTY || gi == `BIT_RX_FULL) begin : g_level
        // Level flags come from the comparators below
      end else begin : g_sticky
        // Set beats clear inside each cell
        sticky_flag u_flag (
          .clk_sys (clk_sys),
          .rst_n   (rst_n),
          .set_evt (set_vec[gi]),
          .clr_evt (clr_vec[gi]),
          .flag_q  (raw[gi])
        );
      end
    end
  endgenerate

  // Transmit empty: disabled FIFO looks empty only while machines run
  // Compare is registered, one cycle late
  level_compare #(
    .LW (LEVEL_W),
    .TW (THR_W)
  ) u_tx_empty (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .level     (tx_level),
    .thr       (tx_thr_q),
    .at_least  (1'b0),
    .force_en  (~ctrl_enable),
    .force_val (fsm_active),
    .flag_q    (tx_empty_q)
  );

  // Receive full: cleared at once while disabled
  // Threshold 0 already means one entry
  level_compare #(
    .LW (LEVEL_W),
    .TW (THR_W)
  ) u_rx_full (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .level     (rx_level),
    .thr       (rx_thr_q),
    .at_least  (1'b1),
    .force_en  (~ctrl_enable),
    .force_val (1'b0),
    .flag_q    (rx_full_q)
  );

  // Level flags join the raw word
  assign raw[`BIT_TX_EMPTY] = tx_empty_q;
  assign raw[`BIT_RX_FULL]  = rx_full_q;

  // Mask gating of every raw flag
  // Reserved bits never reach irq
  assign masked = raw & mask_q;

  // Abort cause loads with the abort event, clears with the flag
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      abort_cause_q <= {`CAUSE_WIDTH{1'b0}};
    end else if (tx_abort_evt) begin
      // New abort overwrites an older reason
      abort_cause_q <= tx_abort_cause;
    end else if (rd_abort | rd_combined) begin
      // Clear read drops the stale reason
      abort_cause_q <= {`CAUSE_WIDTH{1'b0}};
    end
  end

  // Rising edges of raw flags latch until software writes a one
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // No edge pending out of reset
      raw_prev_q    <= `RAW_RESET;
      event_latch_q <= {`FLAG_COUNT{1'b0}};
    end else begin
      // Last raw word for edge finding
      raw_prev_q    <= raw;
      // New edge wins over a clear in the same cycle
      event_latch_q <= (event_latch_q & ~latch_w1c) | (raw & ~raw_prev_q);
    end
  end

  // Flush and interrupt outputs from flops
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // FIFO held until reset is gone
      tx_fifo_flush <= 1'b1;
      irq           <= 1'b0;
      tx_threshold  <= `THR_RESET;
      rx_threshold  <= `THR_RESET;
    end else begin
      // Flush lasts until the abort or combined clear read drops the flag
      tx_fifo_flush <= set_vec[`BIT_TX_ABORT] | raw[`BIT_TX_ABORT] | ~ctrl_enable;
      // Interrupt lags the masked word a cycle
      irq           <= |masked;
      // Thresholds copied out a cycle late
      tx_threshold  <= tx_thr_q;
      rx_threshold  <= rx_thr_q;
    end
  end

  // Read data selection, unmapped addresses read zero
  always @* begin
    rd_mux = 32'h00000000;
    if (haddr == `ADDR_INTR_MASK) begin
      rd_mux[`FLAG_COUNT-1:0] = mask_q;
    end else if (haddr == `ADDR_RAW_STATUS) begin
      rd_mux[`FLAG_COUNT-1:0] = raw;
    end else if (haddr == `ADDR_MASKED_STATUS) begin
      rd_mux[`FLAG_COUNT-1:0] = masked;
    end else if (haddr == `ADDR_TX_THRESHOLD) begin
      // Threshold fields sit in low bits
      rd_mux[THR_W-1:0] = tx_thr_q;
    end else if (haddr == `ADDR_RX_THRESHOLD) begin
      rd_mux[THR_W-1:0] = rx_thr_q;
    end else if (haddr == `ADDR_ABORT_CAUSE) begin
      // Reason stands until a clear read
      rd_mux[`CAUSE_WIDTH-1:0] = abort_cause_q;
    end else if (haddr == `ADDR_EVENT_LATCH) begin
      // Edge history, cleared by writing ones
      rd_mux[`FLAG_COUNT-1:0] = event_latch_q;
    end else if (haddr == `ADDR_COMBINED_CLR) begin
      // Any raw flag pending
      rd_mux[0] = |raw;
    end else if (haddr == `ADDR_GEN_CALL_CLR) begin
      // Flag as it stood before the clear
      rd_mux[0] = raw[`BIT_GEN_CALL];
    end else if (haddr == `ADDR_ACTIVITY_CLR) begin
      rd_mux[0] = raw[`BIT_ACTIVITY];
    end else if (haddr == `ADDR_ABORT_CLR) begin
      rd_mux[0] = raw[`BIT_TX_ABORT];
    end else if (haddr == `ADDR_RD_REQ_CLR) begin
      rd_mux[0] = raw[`BIT_RD_REQ];
    end
    // Unmapped addresses keep the zero default
  end

  // Read data registered at the address phase, stands in the data phase
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Reads out of reset return zero
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      // Selection sampled at the address phase
      hrdata <= rd_mux;
    end
  end

endmodule // i2c_irq_ctrl

// ### hdl/i2c_irq_map.vh
// Register map, field positions, reset values and constants of the I2C interrupt block
// Functional notes
// - Mask bits 11..0 gate matching raw flags
// - Mask resets: start, stop, activity 0; others 1
// - General call set on acked address; sticky
// - Start flag set on START or repeated START
// - Stop flag set on any STOP condition
// - Activity sticky; cleared by disable, reads, reset
// - Slave transmitter NACK sets transmit-done flag
// - Transmit abort flag set on failed transmit
// - Abort cause captured into readable cause register
// - Transmit FIFO flushed while abort flag set
// - FIFO stays flushed until abort or combined clear read
// - Transmit empty while level at or below threshold
// - Receive full while level above threshold
`ifndef I2C_IRQ_MAP_VH
`define I2C_IRQ_MAP_VH

// Byte addresses on the register bus
`define ADDR_INTR_MASK      32'h50001330
`define ADDR_RAW_STATUS     32'h50001334
`define ADDR_RX_THRESHOLD   32'h50001338
`define ADDR_TX_THRESHOLD   32'h5000133C
`define ADDR_MASKED_STATUS  32'h50001340
`define ADDR_COMBINED_CLR   32'h50001344
`define ADDR_GEN_CALL_CLR   32'h50001348
`define ADDR_ACTIVITY_CLR   32'h5000134C
`define ADDR_ABORT_CLR      32'h50001350
`define ADDR_RD_REQ_CLR     32'h50001354
`define ADDR_ABORT_CAUSE    32'h50001358
`define ADDR_EVENT_LATCH    32'h5000135C

// Flag positions, shared by mask, raw and masked status
`define BIT_RX_UNDER   0
`define BIT_RX_OVER    1
`define BIT_RX_FULL    2
`define BIT_TX_OVER    3
`define BIT_TX_EMPTY   4
`define BIT_RD_REQ     5
`define BIT_TX_ABORT   6
`define BIT_TX_DONE    7
`define BIT_ACTIVITY   8
`define BIT_STOP       9
`define BIT_START      10
`define BIT_GEN_CALL   11

// Widths and reset values
`define FLAG_COUNT       12
`define REG_WIDTH        16
`define THR_WIDTH        5
`define LEVEL_WIDTH      6
`define CAUSE_WIDTH      16
`define MASK_RESET       12'h8FF
`define RAW_RESET        12'h000
`define THR_RESET        5'h00

// AHB transfer type and response codes
`define HTRANS_NONSEQ    2'h2
`define HTRANS_SEQ       2'h3
`define HRESP_OKAY       1'h0

`endif

// ### hdl/sticky_flag.v
// Sticky event flag with a set that wins over a simultaneous clear
`timescale 1ns/1ps
module sticky_flag (
  input  wire clk_sys,    // System clock
  input  wire rst_n,      // Synchronised reset, active low
  input  wire set_evt,    // Event pulse that raises the flag
  input  wire clr_evt,    // Clear request
  output reg  flag_q      // Flag state
);

  // Set takes priority so an event in the clear cycle is not lost
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (clr_evt) begin
      flag_q <= 1'b0;
    end
  end

endmodule // sticky_flag

// ### hdl/level_compare.v
// FIFO level against programmed threshold, registered
`timescale 1ns/1ps
module level_compare #(
  parameter LW = 6,       // Level width
  parameter TW = 5        // Threshold width
) (
  input  wire          clk_sys,   // System clock
  input  wire          rst_n,     // Synchronised reset, active low
  input  wire [LW-1:0] level,     // Current FIFO level
  input  wire [TW-1:0] thr,       // Programmed threshold
  input  wire          at_least,  // 1: level >= thr+1, 0: level <= thr
  input  wire          force_en,  // Override active
  input  wire          force_val, // Override value
  output reg           flag_q     // Comparison result
);

  wire [LW-1:0] thr_ext = {{(LW-TW){1'b0}}, thr};  // Threshold at level width
  wire          hit;                                // Raw comparison

  // Receive side counts threshold 0 as one entry
  assign hit = at_least ? (level > thr_ext) : (level <= thr_ext);

  // Flag follows the level, no software clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= force_en ? force_val : hit;
    end
  end

endmodule // level_compare

// ### dv/i2c_irq_chk.sv
// Assertion checker for the I2C interrupt block, bound to its top
`timescale 1ns/1ps
`include "i2c_irq_map.vh"
module i2c_irq_chk #(
  parameter LEVEL_W = 6,  // FIFO level width
  parameter THR_W   = 5   // Threshold width
) (
  input wire             clk_sys,
  input wire             rstn,
  input wire             hsel,
  input wire [31:0]      haddr,
  input wire [1:0]       htrans,
  input wire             hwrite,
  input wire [31:0]      hwdata,
  input wire             hready,
  input wire [31:0]      hrdata,
  input wire             ctrl_enable,
  input wire             tx_abort_evt,
  input wire             tx_fifo_flush,
  input wire [THR_W-1:0] tx_threshold,
  input wire [THR_W-1:0] rx_threshold,
  input wire             irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire       acc = hsel && hready && htrans[1];  // Accepted address phase
  wire       rd  = acc && !hwrite;               // Accepted read
  reg        wr_q;                               // Write now in data phase
  reg [31:0] wa_q;                               // Its address
  reg [31:0] wd_q;                               // Last written word
  // Follow writes into their data phase
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      wa_q <= 32'h0;
      wd_q <= 32'h0;
    end else begin
      wr_q <= acc && hwrite;
      wa_q <= haddr;
      wd_q <= wr_q ? hwdata : wd_q;
    end
  end
  sequence s_abort;
    tx_abort_evt;
  endsequence
  sequence s_wr(a);
    wr_q && (wa_q == a);
  endsequence
  property p_flush_on_abort;
    s_abort |=> ##[0:1] tx_fifo_flush;
  endproperty
  a_flush_on_abort: assert property (p_flush_on_abort)
    else $error("transmit FIFO not flushed after abort");
  // Any read may be a clear, so only read-free stretches are judged
  property p_flush_hold;
    tx_fifo_flush && ctrl_enable && $past(ctrl_enable) && !rd && !$past(rd)
      |=> tx_fifo_flush;
  endproperty
  a_flush_hold: assert property (p_flush_hold)
    else $error("flush dropped without a clear read");
  property p_dis_flush;
    !ctrl_enable |=> tx_fifo_flush;
  endproperty
  a_dis_flush: assert property (p_dis_flush)
    else $error("disabled controller without flush");
  property p_rsvd_zero;
    rd && (haddr == `ADDR_INTR_MASK || haddr == `ADDR_RAW_STATUS)
      |=> hrdata[31:12] == 20'h00000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");
  property p_clr_bit0;
    rd && (haddr == `ADDR_GEN_CALL_CLR || haddr == `ADDR_ACTIVITY_CLR ||
           haddr == `ADDR_COMBINED_CLR) |=> hrdata[31:1] == 31'h0;
  endproperty
  a_clr_bit0: assert property (p_clr_bit0)
    else $error("clear register returned upper bits");
  property p_mask_off;
    s_wr(`ADDR_INTR_MASK) ##0 (hwdata[11:0] == 12'h000) |=> ##1 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("irq high with all events masked");
  property p_tx_thr;
    s_wr(`ADDR_TX_THRESHOLD) |=> ##[0:1] (tx_threshold == wd_q[THR_W-1:0]);
  endproperty
  a_tx_thr: assert property (p_tx_thr)
    else $error("transmit threshold not passed on");
  property p_rx_thr;
    s_wr(`ADDR_RX_THRESHOLD) |=> ##[0:1] (rx_threshold == wd_q[THR_W-1:0]);
  endproperty
  a_rx_thr: assert property (p_rx_thr)
    else $error("receive threshold not passed on");
endmodule  // i2c_irq_chk
bind i2c_irq_ctrl i2c_irq_chk #(.LEVEL_W(LEVEL_W), .THR_W(THR_W)) chk_u (
  .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .ctrl_enable(ctrl_enable), .tx_abort_evt(tx_abort_evt), .tx_fifo_flush(tx_fifo_flush),
  .tx_threshold(tx_threshold), .rx_threshold(rx_threshold), .irq(irq));

// ### dv/i2c_bus_model.sv
// Far-side I2C bus agent: raises bus events as one-cycle pulses
`timescale 1ns/1ps
module i2c_bus_model (
  input  wire        clk_sys,              // System clock
  input  wire [3:0]  evt_idx,              // Flag position of the event
  input  wire        evt_go,               // Request from the bench
  input  wire [15:0] cause_in,             // Abort reason to present
  output reg  [11:0] evt_q = 12'h000,      // Event pulses, one cycle wide
  output reg  [15:0] cause_q = 16'h0000    // Abort reason beside the pulse
);
  // Remote masters and slaves cause these in any role
  always @(posedge clk_sys) begin
    evt_q <= evt_go ? (12'h001 << evt_idx) : 12'h000;
    // Reason only valid with its pulse, scrambled otherwise
    cause_q <= evt_go ? cause_in : ~cause_q;
  end
endmodule  // i2c_bus_model

// ### dv/i2c_irq_ctrl_tb.sv
// Testbench for the I2C interrupt block: register tests over AHB-Lite
`timescale 1ns/1ps
`include "i2c_irq_map.vh"
module i2c_irq_ctrl_tb;
  reg         clk_sys;
  reg         rstn = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  wire        hready;              // Single slave, so its ready is the bus
  wire [31:0] hrdata;
  reg         ctrl_enable = 1'b0;
  reg  [5:0]  tx_level = 6'h00;
  reg  [5:0]  rx_level = 6'h00;
  reg  [3:0]  evt_idx = 4'h0;      // Event chosen for the partner
  reg         evt_go = 1'b0;
  reg  [15:0] cause = 16'h0000;
  wire [11:0] evt;                 // Pulses from the partner
  wire [15:0] evt_cause;
  wire        flush;
  wire        irq;
  wire        hresp;
  integer     num_errors = 0;
  integer     checked = 0;
  integer     i;
  reg  [31:0] q;                   // Last read data
  reg  [11:0] exp_raw = 12'h000;   // Expected raw flags
  i2c_irq_ctrl dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .ctrl_enable(ctrl_enable), .fsm_active(evt[8]),
    .gen_call_ack(evt[11]), .start_seen(evt[10]), .stop_seen(evt[9]),
    .slv_tx_nack(evt[7]), .tx_abort_evt(evt[6]), .tx_abort_cause(evt_cause),
    .rd_req_evt(evt[5]), .tx_over_evt(evt[3]), .rx_over_evt(evt[1]),
    .rx_under_evt(evt[0]), .tx_level(tx_level), .rx_level(rx_level),
    .tx_fifo_flush(flush), .tx_threshold(), .rx_threshold(), .irq(irq));
  i2c_bus_model far_u (.clk_sys(clk_sys), .evt_idx(evt_idx), .evt_go(evt_go),
    .cause_in(cause), .evt_q(evt), .cause_q(evt_cause));
  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One single-word transfer; waits on ready, no fixed latency
  task automatic ahb(input w, input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= `HTRANS_NONSEQ;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      q = hrdata;
    end
  endtask
  task automatic wr(input [31:0] a, input [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdc(input [31:0] a, input [31:0] e);
    begin
      ahb(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask
  // Ask the partner for one event, then let flags and irq settle
  task automatic ev(input [3:0] n);
    begin
      evt_idx <= n;
      evt_go <= 1'b1;
      @(posedge clk_sys);
      evt_go <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // New FIFO levels, then the raw word
  task automatic lvl(input [5:0] t, input [5:0] r, input [31:0] e);
    begin
      tx_level <= t;
      rx_level <= r;
      repeat (3) @(posedge clk_sys);
      rdc(`ADDR_RAW_STATUS, e);
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Hang guard, well beyond the roughly 150 cycles needed
  initial begin
    #(100 * 3000);
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(`ADDR_INTR_MASK, 32'h000008FF);
    rdc(`ADDR_RAW_STATUS, 32'h0);
    rdc(32'h50001360, 32'h0);
    chk(hresp, `HRESP_OKAY);
    wr(`ADDR_INTR_MASK, 32'hFFFFFFFF);
    rdc(`ADDR_INTR_MASK, 32'h00000FFF);
    $display("test reset_and_mask done");
    ctrl_enable <= 1'b1;
    tx_level <= 6'h0A;
    cause <= 16'h00A5;
    // Every pulsed event in turn; flags accumulate
    for (i = 0; i < 12; i = i + 1) begin
      if (i != 2 && i != 4) begin
        ev(i[3:0]);
        exp_raw[i] = 1'b1;
        rdc(`ADDR_RAW_STATUS, {20'h0, exp_raw});
      end
    end
    chk(irq, 1'b1);
    rdc(`ADDR_ABORT_CAUSE, 32'h000000A5);
    chk(flush, 1'b1);
    rdc(`ADDR_GEN_CALL_CLR, 32'h00000001);
    rdc(`ADDR_ACTIVITY_CLR, 32'h00000001);
    exp_raw[11] = 1'b0;
    exp_raw[8] = 1'b0;
    rdc(`ADDR_RAW_STATUS, {20'h0, exp_raw});
    chk(flush, 1'b1);
    $display("test events done");
    wr(`ADDR_INTR_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    wr(`ADDR_INTR_MASK, 32'h00000400);
    repeat (2) @(posedge clk_sys);
    rdc(`ADDR_MASKED_STATUS, 32'h00000400);
    chk(irq, 1'b1);
    rdc(`ADDR_ABORT_CLR, 32'h00000001);
    repeat (2) @(posedge clk_sys);
    chk(flush, 1'b0);
    rdc(`ADDR_RD_REQ_CLR, 32'h00000001);
    rdc(`ADDR_COMBINED_CLR, 32'h00000001);
    rdc(`ADDR_RAW_STATUS, 32'h0);
    rdc(`ADDR_ABORT_CAUSE, 32'h0);
    chk(irq, 1'b0);
    $display("test masking_and_clears done");
    wr(`ADDR_TX_THRESHOLD, 32'h0000000C);
    wr(`ADDR_RX_THRESHOLD, 32'h00000004);
    lvl(6'h0A, 6'h00, 32'h00000010);
    lvl(6'h0C, 6'h00, 32'h00000010);
    lvl(6'h0D, 6'h00, 32'h0);
    lvl(6'h0D, 6'h05, 32'h00000004);
    lvl(6'h0D, 6'h04, 32'h0);
    rdc(`ADDR_EVENT_LATCH, 32'h00000FFF);
    wr(`ADDR_EVENT_LATCH, 32'h00000FFF);
    rdc(`ADDR_EVENT_LATCH, 32'h0);
    $display("test levels done");
    ev(4'hB);
    rdc(`ADDR_RAW_STATUS, 32'h00000800);
    ctrl_enable <= 1'b0;
    lvl(6'h0D, 6'h05, 32'h0);
    $display("test disable done");
    end_sim;
  end
endmodule  // i2c_irq_ctrl_tb
